/* hw/sesf_flags.sv */
/*
 Sticky status flags, Tx write gate, underrun abort, Port 2 gap check.
 Assumes strobes on clk_sys and Port 2 inputs on a free-running clk_link.
*/
`timescale 1ns/1ps
`include "sesf_defs.svh"

// How it works
// R1 - Early chip-select release sets frame loss
// R2 - Control protection error also sets frame loss
// R3 - Failed protected write sets protection error
// R4 - Receive buffer overflow sets its flag
// R5 - Underrun flag only in cut-through mode
// R6 - Underrun stops current packet, sets flag
// R7 - Host feeds cut-through faster than 10 Mbps
// R8 - FIFO overflow sets flag, drops frame
// R9 - After overflow ignore writes until start
// R10 - Overflow never interrupts frame being sent
// R11 - Host checks free space before writing
// R12 - Data chunk without start sets protocol
// R13 - Repeated start chunk sets protocol flag
// R14 - Early frame size write sets protocol
// R15 - Second status at 0x09, resets zero
// R16 - Port 2 CRC mismatch sets bit 24
// R17 - Short gap drops frame, sets bit 23
// R18 - Gap threshold is software programmable
// R19 - Capture slot C sets bit 22
// R20 - Flags hold until one is written
module sesf_flags
    import sesf_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Async reset
    input wire logic [7:0] reg_addr, // Register address
    input wire logic reg_wr, // Register write strobe
    input wire logic [31:0] reg_wdata, // Write data
    input wire logic reg_rd, // Register read strobe
    output logic [31:0] reg_rdata, // Read data, next cycle
    input wire logic generic_spi_mode, // 1: generic SPI, 0: chunk
    input wire logic ctrl_protect_enable, // Control write protection
    input wire logic cut_through_en, // Host cut-through on
    input wire sesf_host_ev_type host_ev, // Host side events
    input wire sesf_chunk_type chunk, // Tx chunk header
    input wire logic fsize_wr, // Frame size write
    input wire logic [`SESF_FSIZE_W-1:0] fsize_value, // Frame size
    input wire logic host_wr_valid, // Host byte write
    input wire logic host_wr_sof, // Byte starts a frame
    input wire logic tx_fifo_full, // Tx FIFO full
    output logic fifo_wr_en, // Store byte in Tx FIFO
    input wire logic tx_in_progress, // MAC sending a frame
    input wire logic tx_fifo_empty, // Tx FIFO empty
    input wire logic tx_eof_sent, // Frame end reached
    output logic tx_abort, // Stop current packet
    input wire logic clk_link, // Port 2 link clock
    input wire sesf_link_ev_type link_ev, // Port 2 events
    input wire logic p2_rx_active, // Port 2 receiving
    output logic p2_rx_drop // Drop frame, link clock
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Set beats clear: an event while clearing is kept
    function automatic logic [31:0] w1c_next(input logic [31:0] cur,
        input logic [31:0] set, input logic [31:0] clr);
        w1c_next = (cur & ~clr) | set;
    endfunction

    logic [31:0] status_host_errors_reg, status_host_errors_next, status_port2_events_reg, status_port2_events_next;
    logic [31:0] set0, set1, clr0, clr1, rdata_reg, rdata_next;
    logic [7:0] gap_reg, gap_next;
    logic wr_s0, wr_s1;
    logic [`SESF_LINK_EVENTS-1:0] link_pulse;

    // ------------------------------------------------------------
    // Host write gate and underrun
    // ------------------------------------------------------------
    sesf_wr_state_type wr_state_reg, wr_state_next;
    logic abort_reg, abort_next, ovf_now, underrun_now;

    // Drop state ignores writes until a new frame
    always_comb begin
        wr_state_next = wr_state_reg;
        ovf_now = 1'b0;
        fifo_wr_en = 1'b0;
        unique case (wr_state_reg)
            WR_ACCEPT: begin
                if (host_wr_valid && tx_fifo_full) begin
                    ovf_now = 1'b1; // R8
                    wr_state_next = WR_DROP; // R8
                end else begin
                    fifo_wr_en = host_wr_valid;
                end
            end
            WR_DROP: begin
                if (host_wr_valid && host_wr_sof) begin
                    if (tx_fifo_full) begin
                        ovf_now = 1'b1;
                    end else begin
                        fifo_wr_en = 1'b1; // R9
                        wr_state_next = WR_ACCEPT; // R9
                    end
                end
            end
        endcase
    end

    // Only an underrun aborts; overflow sits on the write side only
    always_comb begin
        underrun_now = cut_through_en && tx_in_progress // R5
            && tx_fifo_empty && !tx_eof_sent;
        abort_next = underrun_now; // R6 R10
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_state_reg <= WR_ACCEPT;
            abort_reg <= 1'b0;
        end else begin
            wr_state_reg <= wr_state_next;
            abort_reg <= abort_next;
        end
    end
    assign tx_abort = abort_reg;

    // ------------------------------------------------------------
    // Transmit protocol tracking
    // ------------------------------------------------------------
    logic open_reg, open_next, proto_err;
    logic [`SESF_FSIZE_W-1:0] remain_reg, remain_next;

    // Chunk mode follows start/end marks, generic mode counts bytes
    always_comb begin
        open_next = open_reg;
        remain_next = remain_reg;
        proto_err = 1'b0;
        if (!generic_spi_mode) begin
            if (chunk.valid && chunk.chunk_data_valid) begin
                if (!chunk.chunk_start_valid && !open_reg) begin
                    proto_err = 1'b1; // R12
                end
                if (chunk.chunk_start_valid && open_reg
                    && !chunk.chunk_end_valid) begin
                    proto_err = 1'b1; // R13
                end
                open_next = (open_reg || chunk.chunk_start_valid)
                    && !chunk.chunk_end_valid;
            end
        end else if (fsize_wr) begin
            proto_err = (remain_reg != '0); // R14
            remain_next = fsize_value;
        end else if (fifo_wr_en && remain_reg != '0) begin
            remain_next = remain_reg - 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            open_reg <= 1'b0;
            remain_reg <= '0;
        end else begin
            open_reg <= open_next;
            remain_reg <= remain_next;
        end
    end

    // ------------------------------------------------------------
    // Status registers
    // ------------------------------------------------------------
    logic prot_set;

    always_comb begin
        prot_set = ctrl_protect_enable && host_ev.ctrl_check_fail; // R3
        set0 = '0;
        set0[`SESF_LOSS_BIT] = host_ev.cs_early_release // R1
            || prot_set; // R2
        set0[`SESF_PROT_BIT] = prot_set; // R3
        set0[`SESF_RXOV_BIT] = host_ev.rx_buf_overflow; // R4
        set0[`SESF_UNDR_BIT] = underrun_now; // R5 R6
        set0[`SESF_TXOV_BIT] = ovf_now; // R8
        set0[`SESF_TXPE_BIT] = proto_err; // R12 R13 R14
        set1 = '0;
        set1[`SESF_CRC_BIT] = link_pulse[0]; // R16
        set1[`SESF_IFG_BIT] = link_pulse[1]; // R17
        set1[`SESF_TSC_BIT] = link_pulse[2]; // R19
        wr_s0 = reg_wr && reg_addr == `SESF_S0_ADDR;
        wr_s1 = reg_wr && reg_addr == `SESF_S1_ADDR; // R15
        clr0 = wr_s0 ? reg_wdata : '0;
        clr1 = wr_s1 ? reg_wdata : '0;
        status_host_errors_next = w1c_next(status_host_errors_reg, set0, clr0); // R20
        status_port2_events_next = w1c_next(status_port2_events_reg, set1, clr1); // R20
        gap_next = gap_reg;
        if (reg_wr && reg_addr == `SESF_GAP_ADDR) begin
            gap_next = reg_wdata[7:0]; // R18
        end
        rdata_next = rdata_reg;
        if (reg_rd) begin
            unique case (reg_addr)
                `SESF_S0_ADDR: rdata_next = status_host_errors_reg;
                `SESF_S1_ADDR: rdata_next = status_port2_events_reg;
                `SESF_GAP_ADDR: rdata_next = {24'h000000, gap_reg};
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            status_host_errors_reg <= `SESF_S0_RST;
            status_port2_events_reg <= `SESF_S1_RST; // R15
            gap_reg <= `SESF_GAP_RST;
            rdata_reg <= '0;
        end else begin
            status_host_errors_reg <= status_host_errors_next;
            status_port2_events_reg <= status_port2_events_next;
            gap_reg <= gap_next;
            rdata_reg <= rdata_next;
        end
    end
    assign reg_rdata = rdata_reg;

    // ------------------------------------------------------------
    // Threshold handshake into the link domain
    // ------------------------------------------------------------
    // Shadow moves only with no request in flight
    logic req_reg, req_next, ack_s1, ack_s2;
    logic [7:0] shadow_reg, shadow_next;

    always_comb begin
        req_next = req_reg;
        shadow_next = shadow_reg;
        if (ack_s2 == req_reg && shadow_reg != gap_reg) begin
            shadow_next = gap_reg;
            req_next = !req_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            req_reg <= 1'b0;
            shadow_reg <= `SESF_GAP_RST;
        end else begin
            req_reg <= req_next;
            shadow_reg <= shadow_next;
        end
    end

    // ------------------------------------------------------------
    // Link domain: reset release, gap check, event toggles
    // ------------------------------------------------------------
    logic lrst_s1, link_rst_n, req_s1, req_s2, seen_reg, seen_next;
    logic [7:0] thr_reg, thr_next, gcnt_reg, gcnt_next;
    logic act_reg, drop_reg, drop_next;
    logic [`SESF_LINK_EVENTS-1:0] tog_reg, tog_next;

    // Reset asserts at once but releases on a link edge
    always_ff @(posedge clk_link or negedge rst_n) begin
        if (!rst_n) begin
            lrst_s1 <= 1'b0;
            link_rst_n <= 1'b0;
        end else begin
            lrst_s1 <= 1'b1;
            link_rst_n <= lrst_s1;
        end
    end

    // Gap counts idle link clocks and saturates
    always_comb begin
        thr_next = thr_reg;
        seen_next = seen_reg;
        if (req_s2 != seen_reg) begin
            thr_next = shadow_reg; // R18
            seen_next = req_s2;
        end
        gcnt_next = gcnt_reg;
        if (p2_rx_active) begin
            gcnt_next = '0;
        end else if (gcnt_reg != 8'hff) begin
            gcnt_next = gcnt_reg + 8'h01;
        end
        drop_next = p2_rx_active && !act_reg
            && gcnt_reg < thr_reg; // R17
        tog_next = tog_reg;
        tog_next[0] = tog_reg[0] ^ link_ev.port2_tx_crc_mismatch; // R16
        tog_next[1] = tog_reg[1] ^ drop_next; // R17
        tog_next[2] = tog_reg[2] ^ link_ev.port2_ts_capture_c; // R19
    end

    always_ff @(posedge clk_link or negedge link_rst_n) begin
        if (!link_rst_n) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            seen_reg <= 1'b0;
            thr_reg <= `SESF_GAP_RST;
            gcnt_reg <= 8'hff;
            act_reg <= 1'b0;
            drop_reg <= 1'b0;
            tog_reg <= '0;
        end else begin
            req_s1 <= req_reg;
            req_s2 <= req_s1;
            seen_reg <= seen_next;
            thr_reg <= thr_next;
            gcnt_reg <= gcnt_next;
            act_reg <= p2_rx_active;
            drop_reg <= drop_next;
            tog_reg <= tog_next;
        end
    end
    assign p2_rx_drop = drop_reg;

    // ------------------------------------------------------------
    // Back into the system domain
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
        end else begin
            ack_s1 <= seen_reg;
            ack_s2 <= ack_s1;
        end
    end

    // Each toggle passes two flops; the third only feeds the edge
    genvar gi;
    generate
        for (gi = 0; gi < `SESF_LINK_EVENTS; gi++) begin : g_sync
            logic s1, s2, s3;
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                end else begin
                    s1 <= tog_reg[gi];
                    s2 <= s1;
                    s3 <= s2;
                end
            end
            assign link_pulse[gi] = s2 ^ s3;
        end
    endgenerate

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence ovf_seq;
        wr_state_reg == WR_ACCEPT && host_wr_valid && tx_fifo_full;
    endsequence
    sequence drop_hold_seq;
        wr_state_reg == WR_DROP && host_wr_valid && !host_wr_sof;
    endsequence

    loss_on_cs_a: assert property (host_ev.cs_early_release // R1
        |=> status_host_errors_reg[`SESF_LOSS_BIT])
        else $error("frame loss not set on early release");
    loss_with_prot_a: assert property ($rose(status_host_errors_reg[ // R2
        `SESF_PROT_BIT]) |-> status_host_errors_reg[`SESF_LOSS_BIT])
        else $error("frame loss missing with protection error");
    prot_gate_a: assert property ($rose(status_host_errors_reg[ // R3
        `SESF_PROT_BIT]) |-> $past(ctrl_protect_enable))
        else $error("protection error while protection off");
    rxov_set_a: assert property (host_ev.rx_buf_overflow // R4
        |=> status_host_errors_reg[`SESF_RXOV_BIT])
        else $error("rx overflow flag not set");
    underrun_mode_a: assert property ($rose(status_host_errors_reg[ // R5
        `SESF_UNDR_BIT]) |-> $past(cut_through_en))
        else $error("underrun outside cut-through");
    underrun_stop_a: assert property (underrun_now // R6
        |=> tx_abort && status_host_errors_reg[`SESF_UNDR_BIT])
        else $error("underrun did not stop packet");
    overflow_drop_a: assert property (ovf_seq // R8
        |=> status_host_errors_reg[`SESF_TXOV_BIT] && wr_state_reg == WR_DROP)
        else $error("overflow did not drop frame");
    drop_until_sof_a: assert property (drop_hold_seq // R9
        |-> !fifo_wr_en ##1 wr_state_reg == WR_DROP)
        else $error("write stored during drop");
    ovf_no_abort_a: assert property (ovf_seq and !underrun_now // R10
        |=> !tx_abort)
        else $error("overflow aborted transmit");
    chunk_no_start_a: assert property (!generic_spi_mode // R12
        && chunk.valid && chunk.chunk_data_valid
        && !chunk.chunk_start_valid && !open_reg
        |=> status_host_errors_reg[`SESF_TXPE_BIT])
        else $error("missing start not flagged");
    fsize_early_a: assert property (generic_spi_mode && fsize_wr // R14
        && remain_reg != '0 |=> status_host_errors_reg[`SESF_TXPE_BIT])
        else $error("early frame size not flagged");
    flag_hold_a: assert property (status_host_errors_reg[`SESF_RXOV_BIT] // R20
        && !(wr_s0 && reg_wdata[`SESF_RXOV_BIT])
        |=> status_host_errors_reg[`SESF_RXOV_BIT])
        else $error("flag cleared without write one");
    crc_cross_a: assert property ($rose(status_port2_events_reg[ // R16
        `SESF_CRC_BIT]) |-> $past(link_pulse[0]))
        else $error("crc flag without link event");
    short_gap_a: assert property (@(posedge clk_link) // R17
        disable iff (!link_rst_n)
        p2_rx_active && !act_reg && gcnt_reg < thr_reg
        |=> p2_rx_drop ##1 !p2_rx_drop)
        else $error("short gap frame not dropped");
endmodule

/* shared/sesf_defs.svh */
/*
 Offsets, flag positions, reset values and sizes of the flag block.
 Assumes inclusion by bare name.
*/
`ifndef SESF_DEFS_SVH
`define SESF_DEFS_SVH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define SESF_S0_ADDR 8'h08
`define SESF_S1_ADDR 8'h09
`define SESF_GAP_ADDR 8'h0a
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define SESF_S0_RST 32'h0000_0000
`define SESF_S1_RST 32'h0000_0000
`define SESF_GAP_RST 8'h0c
// ------------------------------------------------------------
// Flag positions
// ------------------------------------------------------------
`define SESF_TXPE_BIT 0
`define SESF_TXOV_BIT 1
`define SESF_UNDR_BIT 2
`define SESF_RXOV_BIT 3
`define SESF_LOSS_BIT 4
`define SESF_PROT_BIT 12
`define SESF_TSC_BIT 22
`define SESF_IFG_BIT 23
`define SESF_CRC_BIT 24
// ------------------------------------------------------------
// Sizes
// ------------------------------------------------------------
`define SESF_TX_FIFO_BYTES 4096
`define SESF_FSIZE_W 16
`define SESF_LINK_EVENTS 3
`endif

/* shared/sesf_pkg.sv */
/*
 Types shared by the status flag block and its bench.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package sesf_pkg;
    // Host side one-cycle event pulses
    typedef struct packed {
        logic cs_early_release;
        logic ctrl_check_fail;
        logic rx_buf_overflow;
    } sesf_host_ev_type;
    // One received Tx data chunk header
    typedef struct packed {
        logic valid;
        logic chunk_data_valid;
        logic chunk_start_valid;
        logic chunk_end_valid;
    } sesf_chunk_type;
    // Port 2 events on the link clock, one-cycle pulses
    typedef struct packed {
        logic port2_tx_crc_mismatch;
        logic port2_ts_capture_c;
    } sesf_link_ev_type;
    // Host write side of the Tx FIFO
    typedef enum logic {WR_ACCEPT, WR_DROP} sesf_wr_state_type;
endpackage

/* tb/sesf_host_model.sv */
/*
 Host controller model: reads and writes the status registers.
 Assumes callers enter its tasks just after a clk_sys rising edge.
*/
`timescale 1ns/1ps
module sesf_host_model
    import sesf_pkg::*;
(
    input wire logic clk_sys, // System clock
    output logic [7:0] reg_addr, // Register index
    output logic reg_wr, // Write strobe
    output logic [31:0] reg_wdata, // Write data
    output logic reg_rd, // Read strobe
    input wire logic [31:0] reg_rdata // Read data
);
    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    // Idle bus shows junk so stale values never pass
    initial begin
        reg_addr = 8'hff;
        reg_wr = 1'b0;
        reg_wdata = 32'h5a5a_5a5a;
        reg_rd = 1'b0;
    end
    // One write over one sampling edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // One read; data registers at the strobe edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
endmodule

/* tb/sesf_flags_tb.sv */
/*
 Self-checking bench of the status flag block.
 Assumes the host model drives the register strobes.
*/
`timescale 1ns/1ps
`include "sesf_defs.svh"
module sesf_flags_tb;
    import sesf_pkg::*;
    logic clk_sys, clk_link, rst_n;
    logic [7:0] reg_addr;
    logic reg_wr, reg_rd;
    logic [31:0] reg_wdata, reg_rdata;
    logic generic_spi_mode, ctrl_protect_enable, cut_through_en;
    sesf_host_ev_type host_ev;
    sesf_chunk_type chunk;
    logic fsize_wr, host_wr_valid, host_wr_sof, tx_fifo_full, fifo_wr_en;
    logic [`SESF_FSIZE_W-1:0] fsize_value;
    logic tx_in_progress, tx_fifo_empty, tx_eof_sent, tx_abort;
    sesf_link_ev_type link_ev;
    logic p2_rx_active, p2_rx_drop, abort_seen, drop_seen;
    int error_cnt = 0;
    int total_checks = 0;
    localparam logic [7:0] S0 = `SESF_S0_ADDR;
    localparam logic [7:0] S1 = `SESF_S1_ADDR;
    localparam logic [7:0] GAP = `SESF_GAP_ADDR;

    sesf_flags sesf_flags_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .generic_spi_mode(generic_spi_mode),
        .ctrl_protect_enable(ctrl_protect_enable),
        .cut_through_en(cut_through_en), .host_ev(host_ev), .chunk(chunk),
        .fsize_wr(fsize_wr), .fsize_value(fsize_value),
        .host_wr_valid(host_wr_valid), .host_wr_sof(host_wr_sof),
        .tx_fifo_full(tx_fifo_full), .fifo_wr_en(fifo_wr_en),
        .tx_in_progress(tx_in_progress), .tx_fifo_empty(tx_fifo_empty),
        .tx_eof_sent(tx_eof_sent), .tx_abort(tx_abort),
        .clk_link(clk_link), .link_ev(link_ev),
        .p2_rx_active(p2_rx_active), .p2_rx_drop(p2_rx_drop));
    sesf_host_model sesf_host_model_inst (.clk_sys(clk_sys),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    // ------------------------------------------------------------
    // Clocks and monitors
    // ------------------------------------------------------------
    // Link clock offset so the two edges never line up
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        clk_link = 1'b0;
        #3;
        forever #40 clk_link = ~clk_link;
    end
    // Latch pulses too short to sample from a task
    always @(posedge clk_sys) if (tx_abort === 1'b1) abort_seen <= 1'b1;
    always @(posedge clk_link) if (p2_rx_drop === 1'b1) drop_seen <= 1'b1;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        sesf_host_model_inst.rd(a, d);
        chk("register", d, exp);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic clear_all();
        sesf_host_model_inst.wr(S0, 32'hffff_ffff);
        sesf_host_model_inst.wr(S1, 32'hffff_ffff);
    endtask
    task automatic ev(input logic [2:0] v);
        host_ev = v;
        tick(1);
        host_ev = '0;
    endtask
    task automatic send_chunk(input logic [3:0] v);
        chunk = v;
        tick(1);
        chunk = '0;
    endtask
    task automatic fsize(input int n);
        fsize_value = n[15:0];
        fsize_wr = 1'b1;
        tick(1);
        fsize_wr = 1'b0;
    endtask
    // Host sends n bytes back to back without checking tx_fifo_full
    task automatic put_bytes(input int n);
        for (int i = 0; i < n; i++) begin
            host_wr_valid = 1'b1;
            host_wr_sof = (i == 0);
            tick(1);
        end
        host_wr_valid = 1'b0;
        host_wr_sof = 1'b0;
    endtask
    task automatic link_pulse(input logic [1:0] v);
        @(posedge clk_link);
        #1;
        link_ev = v;
        @(posedge clk_link);
        #1;
        link_ev = '0;
        tick(10);
    endtask
    // Two frames with a given idle gap
    task automatic frames(input int idle);
        drop_seen = 1'b0;
        @(posedge clk_link);
        #1;
        p2_rx_active = 1'b1;
        repeat (3) @(posedge clk_link);
        #1;
        p2_rx_active = 1'b0;
        repeat (idle) @(posedge clk_link);
        #1;
        p2_rx_active = 1'b1;
        repeat (4) @(posedge clk_link);
        #1;
        p2_rx_active = 1'b0;
        tick(10);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rdchk(S0, `SESF_S0_RST);
        rdchk(S1, `SESF_S1_RST);
        rdchk(GAP, {24'h0, `SESF_GAP_RST});
        $display("test reset done");
    endtask
    task automatic t_host_events();
        ev(3'b100);
        rdchk(S0, 32'h0000_0010);
        sesf_host_model_inst.wr(S0, 32'h0);
        rdchk(S0, 32'h0000_0010);
        sesf_host_model_inst.wr(S0, 32'h0000_0010);
        rdchk(S0, 32'h0);
        ev(3'b010);
        rdchk(S0, 32'h0);
        ctrl_protect_enable = 1'b1;
        ev(3'b010);
        rdchk(S0, 32'h0000_1010);
        clear_all();
        ev(3'b001);
        rdchk(S0, 32'h0000_0008);
        clear_all();
        $display("test host events done");
    endtask
    task automatic t_underrun();
        abort_seen = 1'b0;
        tx_in_progress = 1'b1;
        tx_fifo_empty = 1'b1;
        tick(4);
        chk("abort", abort_seen, 1'b0);
        rdchk(S0, 32'h0);
        cut_through_en = 1'b1;
        tick(3);
        chk("abort", abort_seen, 1'b1);
        tx_in_progress = 1'b0;
        rdchk(S0, 32'h0000_0004);
        clear_all();
        cut_through_en = 1'b0;
        tx_fifo_empty = 1'b0;
        $display("test underrun done");
    endtask
    task automatic t_overflow();
        abort_seen = 1'b0;
        tx_in_progress = 1'b1;
        tx_fifo_full = 1'b1;
        host_wr_valid = 1'b1;
        host_wr_sof = 1'b1;
        #1 chk("wr_en", fifo_wr_en, 1'b0);
        tick(1);
        tx_fifo_full = 1'b0;
        host_wr_sof = 1'b0;
        #1 chk("wr_en", fifo_wr_en, 1'b0);
        tick(1);
        host_wr_sof = 1'b1;
        #1 chk("wr_en", fifo_wr_en, 1'b1);
        tick(1);
        host_wr_valid = 1'b0;
        host_wr_sof = 1'b0;
        rdchk(S0, 32'h0000_0002);
        chk("abort", abort_seen, 1'b0);
        clear_all();
        tx_in_progress = 1'b0;
        $display("test overflow done");
    endtask
    task automatic t_protocol();
        send_chunk(4'b1100);
        rdchk(S0, 32'h0000_0001);
        clear_all();
        send_chunk(4'b1110);
        send_chunk(4'b1110);
        rdchk(S0, 32'h0000_0001);
        send_chunk(4'b1101);
        clear_all();
        send_chunk(4'b1110);
        send_chunk(4'b1100);
        send_chunk(4'b1101);
        rdchk(S0, 32'h0);
        generic_spi_mode = 1'b1;
        fsize(2);
        put_bytes(2);
        fsize(3);
        rdchk(S0, 32'h0);
        put_bytes(1);
        fsize(1);
        rdchk(S0, 32'h0000_0001);
        put_bytes(1);
        clear_all();
        generic_spi_mode = 1'b0;
        $display("test protocol done");
    endtask
    task automatic t_link();
        link_pulse(2'b10);
        rdchk(S1, 32'h0100_0000);
        clear_all();
        link_pulse(2'b01);
        rdchk(S1, 32'h0040_0000);
        clear_all();
        frames(5);
        chk("drop", drop_seen, 1'b1);
        rdchk(S1, 32'h0080_0000);
        clear_all();
        sesf_host_model_inst.wr(GAP, 32'h0000_0002);
        tick(80);
        frames(5);
        chk("drop", drop_seen, 1'b0);
        rdchk(S1, 32'h0);
        $display("test link done");
    endtask

    // ------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Run needs under 2000 cycles
    initial begin
        #200000;
        error_cnt++;
        print_verdict();
    end
    initial begin
        rst_n = 1'b0;
        generic_spi_mode = 1'b0;
        ctrl_protect_enable = 1'b0;
        cut_through_en = 1'b0;
        host_ev = '0;
        chunk = '0;
        fsize_wr = 1'b0;
        fsize_value = '0;
        host_wr_valid = 1'b0;
        host_wr_sof = 1'b0;
        tx_fifo_full = 1'b0;
        tx_in_progress = 1'b0;
        tx_fifo_empty = 1'b0;
        tx_eof_sent = 1'b0;
        link_ev = '0;
        p2_rx_active = 1'b0;
        abort_seen = 1'b0;
        drop_seen = 1'b0;
        tick(10);
        rst_n = 1'b1;
        tick(30);
        t_reset();
        t_host_events();
        t_underrun();
        t_overflow();
        t_protocol();
        t_link();
        print_verdict();
    end
endmodule
